//--- common/ctm_pkg.sv
// Shared constants and carrier types for the codec terminal and clock mux.
// Assumes one 100 MHz clock; every pin level and field arrives synchronous to it.
package ctm_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CTM_CLK_PERIOD_NS = 10; // Reference clock period

  // ****************************************************************
  // Source terminal indices (bit positions of the source vector)
  // ****************************************************************
  localparam int CTM_NSRC = 10;
  localparam int CTM_SRC_MCLK = 0;
  localparam int CTM_SRC_P1_BIT = 1;
  localparam int CTM_SRC_P1_FRAME = 2;
  localparam int CTM_SRC_P1_SERIN = 3;
  localparam int CTM_SRC_P2_BIT = 4;
  localparam int CTM_SRC_P2_FRAME = 5;
  localparam int CTM_SRC_P2_SERIN = 6;
  localparam int CTM_SRC_GP1 = 7;
  localparam int CTM_SRC_GP2 = 8;
  localparam int CTM_SRC_GP3 = 9;

  // ****************************************************************
  // Select decode maps: per source {listed, code[4:0]}, source 0 lowest
  // ****************************************************************
  localparam logic [5:0] CTM_NO = 6'h00; // Source not reachable from this field
  localparam logic [59:0] CTM_MAP_PLL = {6'h25, 6'h27, 6'h22, CTM_NO, CTM_NO, 6'h24,
                                         6'h23, CTM_NO, 6'h21, 6'h20};
  localparam logic [59:0] CTM_MAP_ADC = {6'h25, 6'h29, 6'h22, CTM_NO, CTM_NO, 6'h24,
                                         CTM_NO, CTM_NO, 6'h21, 6'h20};
  localparam logic [59:0] CTM_MAP_DIV = {6'h29, CTM_NO, CTM_NO, CTM_NO, CTM_NO, 6'h28,
                                         6'h22, CTM_NO, 6'h21, 6'h20};
  localparam logic [59:0] CTM_MAP_LF = {6'h25, 6'h28, 6'h22, 6'h26, 6'h23, 6'h24,
                                        CTM_NO, 6'h21, CTM_NO, 6'h20};
  localparam logic [59:0] CTM_MAP_HF = {CTM_NO, CTM_NO, CTM_NO, CTM_NO, CTM_NO, CTM_NO,
                                        CTM_NO, CTM_NO, CTM_NO, 6'h20};

  // ****************************************************************
  // Terminal configuration codes
  // ****************************************************************
  localparam logic [1:0] CTM_SERIN_CLK_IN = 2'h1;   // Serial-in pin used as clock input
  localparam logic [3:0] CTM_PORT2_CLK_IN = 4'h2;   // Port-2 clock pin used as input
  localparam logic [4:0] CTM_GP_CLK_IN = 5'h01;     // General pin used as clock input
  localparam logic [3:0] CTM_SEROUT_DIVIDED_CLOCK_OUTPUT = 4'h3;  // Divided clock on miso / serial out
  localparam logic [3:0] CTM_FRAMEBIT_DIVIDED_CLOCK_OUTPUT = 4'h4; // Divided clock on frame / bit clock
  localparam logic [4:0] CTM_GP_DIVIDED_CLOCK_OUTPUT = 5'h04;     // Divided clock on general pin
  localparam logic [7:0] CTM_DIV_HALF_MAX = 8'h80;  // High phase when divider is 256

  // Output terminal indices
  localparam int CTM_NOUT = 7;
  localparam int CTM_OUT_MISO = 0;
  localparam int CTM_OUT_P1_FRAME = 1;
  localparam int CTM_OUT_P1_SEROUT = 2;
  localparam int CTM_OUT_P2_FRAME = 3;
  localparam int CTM_OUT_P2_BIT = 4;
  localparam int CTM_OUT_GP1 = 5;
  localparam int CTM_OUT_GP2 = 6;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic [3:0] pll_source_sel;
    logic [3:0] adc_clk_source_sel;
    logic [3:0] dac_clk_source_sel;
    logic [4:0] divider_source_sel;
    logic [7:0] clock_output_divider;
    logic one_mhz_ref_enable;
    logic [3:0] lowfreq_source_sel;
    logic [3:0] highfreq_source_sel;
    logic [1:0] port1_serin_pin_cfg;
    logic [1:0] port2_serin_pin_cfg;
    logic [3:0] port2_bitclk_pin_cfg;
    logic [3:0] port2_frameclk_pin_cfg;
    logic [3:0] port1_frameclk_pin_cfg;
    logic [3:0] port1_serout_pin_cfg;
    logic [3:0] ctrl_miso_pin_cfg;
    logic [4:0] gp1_pin_cfg;
    logic [4:0] gp2_pin_cfg;
    logic [4:0] gp3_pin_cfg;
  } ctm_cfg_t;

  typedef struct packed {
    logic general_pin_3;
    logic general_pin_2;
    logic general_pin_1;
    logic port2_serial_in_pin;
    logic port2_frame_clock_pin;
    logic port2_bit_clock_pin;
    logic port1_serial_in_pin;
    logic port1_frame_clock_pin;
    logic port1_bit_clock_pin;
    logic master_clock_pin;
  } ctm_pins_t;

  typedef struct packed {
    logic clk;
    logic valid;
  } ctm_route_t;

endpackage

//--- core/ctm_clk_sel.sv
// One clock-input selector: decodes a select field against a source map.
// Assumes source levels are already gated by their terminal configuration.
`timescale 1ns/1ps
module ctm_clk_sel #(
  parameter logic [59:0] MAP = 60'h0 // Per source {listed, code}
) (
  input wire logic ref_clk_i,               // System clock
  input wire logic reset_i,                 // Synchronous reset, high
  input wire logic [9:0] src_i,             // Candidate terminal levels
  input wire logic [4:0] sel_i,             // Select field, zero extended
  output ctm_pkg::ctm_route_t route_o       // Routed level and source valid
);
  import ctm_pkg::*;

  logic [CTM_NSRC-1:0] hit;
  ctm_route_t route_r;
  ctm_route_t route_nxt;

  // ****************************************************************
  // Decode
  // ****************************************************************
  // Several selectors may name the same source at once
  for (genvar i = 0; i < CTM_NSRC; i++) begin : g_hit
    assign hit[i] = MAP[i*6+5] && (MAP[i*6 +: 5] == sel_i);
  end

  // Unlisted code: no hit, input stays low and invalid
  always_comb begin
    route_nxt.valid = |hit;
    route_nxt.clk = |(hit & src_i);
  end

  // Register the routed level
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      route_r <= '0;
    end else begin
      route_r <= route_nxt;
    end
  end

  assign route_o = route_r;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);

  a_unlisted_quiet: assert property (!(|hit) |=> !route_o.valid && !route_o.clk)
    else $error("unlisted select code produced a clock");
  a_listed_follows: assert property (|hit |=> route_o.valid
      && route_o.clk == $past(|(hit & src_i)))
    else $error("listed source not routed");

endmodule // ctm_clk_sel

//--- core/ctm_terminal_mux.sv
// Terminal and clock-source mux: control pins by strap, clocks by fields.
// Assumes fields come from the host register file and pins are sampled levels.
`timescale 1ns/1ps
module ctm_terminal_mux (
  input wire logic ref_clk_i,                  // System clock, 100 MHz
  input wire logic reset_i,                    // Synchronous reset, high
  input wire logic protocol_select_strap_i,    // High selects SPI control
  input wire logic addr_or_sclk_pin_i,         // Address strap or SPI clock
  input wire logic spi_miso_data_i,            // Serial data from SPI engine
  input wire logic spi_miso_oe_i,              // SPI engine drives MISO
  input wire ctm_pkg::ctm_pins_t pins_i,       // Clock-capable terminal levels
  input wire ctm_pkg::ctm_cfg_t cfg_i,         // Select and terminal fields
  output logic spi_mode_o,                     // Control port is in SPI mode
  output logic i2c_addr_sel_o,                 // I2C slave address choice
  output logic spi_sclk_o,                     // SPI clock toward the engine
  output ctm_pkg::ctm_route_t pll_ref_o,       // PLL reference input
  output ctm_pkg::ctm_route_t adc_clk_o,       // ADC clock input
  output ctm_pkg::ctm_route_t dac_clk_o,       // DAC clock input
  output ctm_pkg::ctm_route_t div_clk_o,       // Divider clock input
  output ctm_pkg::ctm_route_t lowfreq_clk_o,   // Low-frequency reference input
  output ctm_pkg::ctm_route_t highfreq_clk_o,  // High-frequency clock input
  output logic one_mhz_ref_o,                  // 1 MHz reference input
  output logic [6:0] pin_out_o,                // Output terminal levels
  output logic [6:0] pin_oe_o                  // Output terminal enables
);
  import ctm_pkg::*;

  // ****************************************************************
  // Source gating
  // ****************************************************************
  logic [CTM_NSRC-1:0] src_raw;
  logic [CTM_NSRC-1:0] src_ok;
  logic [CTM_NSRC-1:0] src;

  assign src_raw = pins_i;

  // A pin left in another function reads low at the clock inputs, except the port-1 frame clock pin, which is never gated
  always_comb begin
    src_ok = '1;
    src_ok[CTM_SRC_P1_SERIN] = (cfg_i.port1_serin_pin_cfg == CTM_SERIN_CLK_IN);
    src_ok[CTM_SRC_P2_BIT] = (cfg_i.port2_bitclk_pin_cfg == CTM_PORT2_CLK_IN);
    src_ok[CTM_SRC_P2_FRAME] = (cfg_i.port2_frameclk_pin_cfg == CTM_PORT2_CLK_IN);
    src_ok[CTM_SRC_P2_SERIN] = (cfg_i.port2_serin_pin_cfg == CTM_SERIN_CLK_IN);
    src_ok[CTM_SRC_GP1] = (cfg_i.gp1_pin_cfg == CTM_GP_CLK_IN);
    src_ok[CTM_SRC_GP2] = (cfg_i.gp2_pin_cfg == CTM_GP_CLK_IN);
    src_ok[CTM_SRC_GP3] = (cfg_i.gp3_pin_cfg == CTM_GP_CLK_IN);
    src = src_raw & src_ok;
  end

  // ****************************************************************
  // Clock input selectors
  // ****************************************************************
  ctm_clk_sel #(.MAP(CTM_MAP_PLL)) u_pll (
    .ref_clk_i(ref_clk_i), .reset_i(reset_i), .src_i(src),
    .sel_i({1'b0, cfg_i.pll_source_sel}), .route_o(pll_ref_o));
  ctm_clk_sel #(.MAP(CTM_MAP_ADC)) u_adc (
    .ref_clk_i(ref_clk_i), .reset_i(reset_i), .src_i(src),
    .sel_i({1'b0, cfg_i.adc_clk_source_sel}), .route_o(adc_clk_o));
  ctm_clk_sel #(.MAP(CTM_MAP_ADC)) u_dac (
    .ref_clk_i(ref_clk_i), .reset_i(reset_i), .src_i(src),
    .sel_i({1'b0, cfg_i.dac_clk_source_sel}), .route_o(dac_clk_o));
  ctm_clk_sel #(.MAP(CTM_MAP_DIV)) u_div (
    .ref_clk_i(ref_clk_i), .reset_i(reset_i), .src_i(src),
    .sel_i(cfg_i.divider_source_sel), .route_o(div_clk_o));
  ctm_clk_sel #(.MAP(CTM_MAP_LF)) u_lf (
    .ref_clk_i(ref_clk_i), .reset_i(reset_i), .src_i(src),
    .sel_i({1'b0, cfg_i.lowfreq_source_sel}), .route_o(lowfreq_clk_o));
  ctm_clk_sel #(.MAP(CTM_MAP_HF)) u_hf (
    .ref_clk_i(ref_clk_i), .reset_i(reset_i), .src_i(src),
    .sel_i({1'b0, cfg_i.highfreq_source_sel}), .route_o(highfreq_clk_o));

  // ****************************************************************
  // Divided clock generator
  // ****************************************************************
  logic div_prev_r;
  logic div_prev_nxt;
  logic [7:0] div_cnt_r;
  logic [7:0] div_cnt_nxt;
  logic dco_r;
  logic dco_nxt;
  logic [7:0] div_last;
  logic [7:0] div_half;

  // Counts rising edges of the routed divider source; zero divides by 256
  always_comb begin
    div_last = 8'(cfg_i.clock_output_divider - 8'h01);
    div_half = (cfg_i.clock_output_divider == 8'h00) ? CTM_DIV_HALF_MAX
                                                     : (cfg_i.clock_output_divider >> 1);
    div_prev_nxt = div_clk_o.clk;
    div_cnt_nxt = div_cnt_r;
    if (!div_clk_o.valid) begin
      div_cnt_nxt = 8'h00;
    end else if (div_clk_o.clk && !div_prev_r) begin
      div_cnt_nxt = (div_cnt_r == div_last) ? 8'h00 : 8'(div_cnt_r + 8'h01);
    end
    dco_nxt = div_clk_o.valid && (div_cnt_nxt < div_half);
  end

  // Divider state registers
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      div_prev_r <= 1'b0;
      div_cnt_r <= 8'h00;
      dco_r <= 1'b0;
    end else begin
      div_prev_r <= div_prev_nxt;
      div_cnt_r <= div_cnt_nxt;
      dco_r <= dco_nxt;
    end
  end

  // ****************************************************************
  // Control terminals and output terminals
  // ****************************************************************
  logic [4:0] pin_cfg [CTM_NOUT];
  logic [4:0] pin_code [CTM_NOUT];
  logic [CTM_NOUT-1:0] pin_hit;
  logic spi_mode_r, spi_mode_nxt;
  logic i2c_addr_r, i2c_addr_nxt;
  logic sclk_r, sclk_nxt;
  logic one_mhz_r, one_mhz_nxt;
  logic [6:0] pin_out_r, pin_out_nxt;
  logic [6:0] pin_oe_r, pin_oe_nxt;

  assign pin_cfg[CTM_OUT_MISO] = {1'b0, cfg_i.ctrl_miso_pin_cfg};
  assign pin_cfg[CTM_OUT_P1_FRAME] = {1'b0, cfg_i.port1_frameclk_pin_cfg};
  assign pin_cfg[CTM_OUT_P1_SEROUT] = {1'b0, cfg_i.port1_serout_pin_cfg};
  assign pin_cfg[CTM_OUT_P2_FRAME] = {1'b0, cfg_i.port2_frameclk_pin_cfg};
  assign pin_cfg[CTM_OUT_P2_BIT] = {1'b0, cfg_i.port2_bitclk_pin_cfg};
  assign pin_cfg[CTM_OUT_GP1] = cfg_i.gp1_pin_cfg;
  assign pin_cfg[CTM_OUT_GP2] = cfg_i.gp2_pin_cfg;
  assign pin_code[CTM_OUT_MISO] = {1'b0, CTM_SEROUT_DIVIDED_CLOCK_OUTPUT};
  assign pin_code[CTM_OUT_P1_FRAME] = {1'b0, CTM_FRAMEBIT_DIVIDED_CLOCK_OUTPUT};
  assign pin_code[CTM_OUT_P1_SEROUT] = {1'b0, CTM_SEROUT_DIVIDED_CLOCK_OUTPUT};
  assign pin_code[CTM_OUT_P2_FRAME] = {1'b0, CTM_FRAMEBIT_DIVIDED_CLOCK_OUTPUT};
  assign pin_code[CTM_OUT_P2_BIT] = {1'b0, CTM_FRAMEBIT_DIVIDED_CLOCK_OUTPUT};
  assign pin_code[CTM_OUT_GP1] = CTM_GP_DIVIDED_CLOCK_OUTPUT;
  assign pin_code[CTM_OUT_GP2] = CTM_GP_DIVIDED_CLOCK_OUTPUT;

  // One field per terminal picks its driven function; the port-1 frame clock pin still feeds the selectors while driven
  for (genvar i = 0; i < CTM_NOUT; i++) begin : g_pin
    assign pin_hit[i] = (pin_cfg[i] == pin_code[i]);
  end

  // Strap follows its level; the miso terminal belongs to SPI in SPI mode
  always_comb begin
    spi_mode_nxt = protocol_select_strap_i;
    i2c_addr_nxt = spi_mode_r ? i2c_addr_r : addr_or_sclk_pin_i;
    sclk_nxt = spi_mode_r & addr_or_sclk_pin_i;
    one_mhz_nxt = cfg_i.one_mhz_ref_enable & src_raw[CTM_SRC_MCLK];
    pin_out_nxt = pin_hit & {CTM_NOUT{dco_r}};
    pin_oe_nxt = pin_hit;
    if (spi_mode_r) begin
      pin_out_nxt[CTM_OUT_MISO] = spi_miso_data_i;
      pin_oe_nxt[CTM_OUT_MISO] = spi_miso_oe_i;
    end
  end

  // Reset leaves every terminal undriven, its default input role
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      spi_mode_r <= 1'b0;
      i2c_addr_r <= 1'b0;
      sclk_r <= 1'b0;
      one_mhz_r <= 1'b0;
      pin_out_r <= 7'h00;
      pin_oe_r <= 7'h00;
    end else begin
      spi_mode_r <= spi_mode_nxt;
      i2c_addr_r <= i2c_addr_nxt;
      sclk_r <= sclk_nxt;
      one_mhz_r <= one_mhz_nxt;
      pin_out_r <= pin_out_nxt;
      pin_oe_r <= pin_oe_nxt;
    end
  end

  assign spi_mode_o = spi_mode_r;
  assign i2c_addr_sel_o = i2c_addr_r;
  assign spi_sclk_o = sclk_r;
  assign one_mhz_ref_o = one_mhz_r;
  assign pin_out_o = pin_out_r;
  assign pin_oe_o = pin_oe_r;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);

  sequence s_strap_high;
    protocol_select_strap_i ##1 spi_mode_o;
  endsequence

  // The first edge after reset still shows the reset value, not the strap
  a_strap_mode: assert property (!$past(reset_i) |-> spi_mode_o == $past(protocol_select_strap_i))
    else $error("control mode does not follow strap");
  a_spi_sclk: assert property (s_strap_high |=> spi_sclk_o == $past(addr_or_sclk_pin_i)
      && $stable(i2c_addr_sel_o))
    else $error("sclk or address wrong in spi mode");
  a_i2c_addr: assert property (!spi_mode_o |=> i2c_addr_sel_o == $past(addr_or_sclk_pin_i)
      && !spi_sclk_o)
    else $error("address strap not taken in i2c mode");
  a_spi_miso: assert property (spi_mode_o |=> pin_oe_o[CTM_OUT_MISO] == $past(spi_miso_oe_i)
      && pin_out_o[CTM_OUT_MISO] == $past(spi_miso_data_i))
    else $error("miso terminal taken from spi");
  a_pin_exclusive: assert property (cfg_i.gp1_pin_cfg != CTM_GP_DIVIDED_CLOCK_OUTPUT
      |=> !pin_oe_o[CTM_OUT_GP1] && !pin_out_o[CTM_OUT_GP1])
    else $error("terminal driven without its function");
  a_divided_clock_output_gp2: assert property (cfg_i.gp2_pin_cfg == CTM_GP_DIVIDED_CLOCK_OUTPUT
      |=> pin_oe_o[CTM_OUT_GP2] && pin_out_o[CTM_OUT_GP2] == $past(dco_r))
    else $error("divided clock missing on general pin 2");
  a_shared_mclk: assert property (cfg_i.pll_source_sel == 4'h0 && cfg_i.adc_clk_source_sel == 4'h0
      && cfg_i.dac_clk_source_sel == 4'h0 |=> pll_ref_o.valid && adc_clk_o.valid
      && dac_clk_o.clk == $past(src_raw[CTM_SRC_MCLK])
      && pll_ref_o.clk == dac_clk_o.clk)
    else $error("master clock not shared");
  a_hf_mclk: assert property (cfg_i.highfreq_source_sel == 4'h0
      |=> highfreq_clk_o.valid && highfreq_clk_o.clk == $past(src_raw[CTM_SRC_MCLK]))
    else $error("high frequency input not on master clock");
  a_one_mhz: assert property (one_mhz_ref_o |-> $past(cfg_i.one_mhz_ref_enable))
    else $error("1 MHz reference without enable");
  a_gp_gate: assert property (cfg_i.pll_source_sel == 4'h7 && cfg_i.gp2_pin_cfg != CTM_GP_CLK_IN
      |=> !pll_ref_o.clk)
    else $error("general pin clock leaked without input config");
  a_div_undef: assert property (cfg_i.divider_source_sel == 5'h07
      |=> !div_clk_o.valid ##1 !dco_r)
    else $error("unlisted divider code ran the divider");

endmodule // ctm_terminal_mux

//--- testbench/ctm_src_model.sv
// External clock sources seen by the terminal mux: ten terminal levels.
// Assumes the bench clock; every source toggles at most every other cycle.
`timescale 1ns/1ps
module ctm_src_model (
  input wire logic ref_clk_i, // Bench clock
  output ctm_pkg::ctm_pins_t pins_o // Terminal levels toward the mux
);
  import ctm_pkg::*;
  logic [15:0] cnt_r = 16'h0000;
  // Free counter; sources run slower than half the clock so edges are seen
  always @(posedge ref_clk_i) begin
    cnt_r <= cnt_r + 16'h0001;
  end
  // Mixed rates and phases so that a wrong source choice shows as a mismatch
  always_comb begin
    for (int i = 0; i < 10; i++) begin
      pins_o[i] = cnt_r[1 + i % 4] ^ cnt_r[6 + i % 3];
    end
  end
endmodule // ctm_src_model

//--- testbench/ctm_terminal_mux_tb.sv
// Self-checking bench for the terminal and clock-source mux.
// Assumes outputs follow inputs by one edge and are zero during reset.
`timescale 1ns/1ps
module ctm_terminal_mux_tb;
  import ctm_pkg::*;
  // ****************************************************************
  // Decode tables written from the select code lists
  // ****************************************************************
  localparam int PLL_T[16] = '{0:0, 1:1, 2:7, 3:3, 4:4, 5:9, 7:8, default:-1};
  localparam int ADC_T[16] = '{0:0, 1:1, 2:7, 4:4, 5:9, 9:8, default:-1};
  localparam int DIV_T[32] = '{0:0, 1:1, 2:3, 8:4, 9:9, default:-1};
  localparam int LF_T[16] = '{0:0, 1:2, 2:7, 3:5, 4:4, 5:9, 6:6, 8:8, default:-1};
  logic ref_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic strap = 1'b0, addr = 1'b0, miso_d = 1'b0, miso_oe = 1'b0;
  ctm_cfg_t cfg = '0, p_cfg = '0;
  ctm_pins_t pins, p_pins = '0;
  logic p_strap = 1'b0, p_strap2 = 1'b0, p_addr = 1'b0, p_md = 1'b0, p_mo = 1'b0, p_mode = 1'b0;
  logic spi_mode_o, i2c_addr_sel_o, spi_sclk_o, one_mhz_ref_o;
  ctm_route_t pll_ref_o, adc_clk_o, dac_clk_o, div_clk_o, lowfreq_clk_o, highfreq_clk_o;
  logic [6:0] pin_out_o, pin_oe_o, oe_e, omask, cmask;
  // Divider model state: counter, last source level, output, source route
  int m_cnt = 0, d_m = 256;
  logic m_prev = 1'b0, m_dco = 1'b0, m_dco_old = 1'b0;
  logic [7:0] e_div, m_rt = 8'h00;
  int alive = 0, fail_count = 0, check_count = 0, seed;
  initial begin
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  ctm_src_model src (.ref_clk_i(ref_clk_i), .pins_o(pins));
  ctm_terminal_mux dut (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
    .protocol_select_strap_i(strap), .addr_or_sclk_pin_i(addr), .spi_miso_data_i(miso_d),
    .spi_miso_oe_i(miso_oe), .pins_i(pins), .cfg_i(cfg), .spi_mode_o(spi_mode_o),
    .i2c_addr_sel_o(i2c_addr_sel_o), .spi_sclk_o(spi_sclk_o), .pll_ref_o(pll_ref_o),
    .adc_clk_o(adc_clk_o), .dac_clk_o(dac_clk_o), .div_clk_o(div_clk_o),
    .lowfreq_clk_o(lowfreq_clk_o), .highfreq_clk_o(highfreq_clk_o),
    .one_mhz_ref_o(one_mhz_ref_o), .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o));
  // ****************************************************************
  // Reporting
  // ****************************************************************
  task automatic check(string n, logic [7:0] seen, logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic wrap_up();
    $display("Checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // ****************************************************************
  // Reference model
  // ****************************************************************
  // A source terminal that needs an input setting reads as low without it
  function automatic logic gate(int s);
    case (s)
      3: return p_cfg.port1_serin_pin_cfg == 2'h1;
      4: return p_cfg.port2_bitclk_pin_cfg == 4'h2;
      5: return p_cfg.port2_frameclk_pin_cfg == 4'h2;
      6: return p_cfg.port2_serin_pin_cfg == 2'h1;
      7: return p_cfg.gp1_pin_cfg == 5'h01;
      8: return p_cfg.gp2_pin_cfg == 5'h01;
      9: return p_cfg.gp3_pin_cfg == 5'h01;
      default: return 1'b1;
    endcase
  endfunction
  function automatic logic [7:0] rt(int s);
    if (s < 0) return 8'h00;
    return {6'h00, p_pins[s] & gate(s), 1'b1};
  endfunction
  // Capture what the design samples at each edge
  always @(posedge ref_clk_i) begin
    p_cfg <= cfg;
    p_pins <= pins;
    p_strap <= strap;
    p_strap2 <= p_strap;
    p_addr <= addr;
    p_md <= miso_d;
    p_mo <= miso_oe;
    p_mode <= spi_mode_o;
    alive <= reset_i ? 0 : (alive < 3 ? alive + 1 : alive);
  end
  // Outputs are settled by the falling edge
  always @(negedge ref_clk_i) begin
    // Divider model: counts source rises, wraps at M (0 is 256), high below M/2
    e_div = rt(DIV_T[p_cfg.divider_source_sel]);
    d_m = (p_cfg.clock_output_divider == 8'h00) ? 256 : int'(p_cfg.clock_output_divider);
    m_dco_old = m_dco;
    if (alive == 0) begin
      m_cnt = 0;
      m_prev = 1'b0;
      m_dco = 1'b0;
      m_rt = 8'h00;
    end else begin
      if (!m_rt[0]) begin
        m_cnt = 0;
      end else if (m_rt[1] && !m_prev) begin
        m_cnt = (m_cnt == d_m - 1) ? 0 : (m_cnt + 1) % 256;
      end
      m_prev = m_rt[1];
      m_dco = m_rt[0] && (m_cnt < d_m / 2);
      m_rt = e_div;
    end
    if (alive == 0 && reset_i) begin
      check("reset oe", {1'b0, pin_oe_o}, 8'h00);
      check("reset routes", {2'b00, pll_ref_o, adc_clk_o, lowfreq_clk_o}, 8'h00);
    end else if (alive >= 2) begin
      check("pll", 8'(pll_ref_o), rt(PLL_T[p_cfg.pll_source_sel]));
      check("adc", 8'(adc_clk_o), rt(ADC_T[p_cfg.adc_clk_source_sel]));
      check("dac", 8'(dac_clk_o), rt(ADC_T[p_cfg.dac_clk_source_sel]));
      check("div", 8'(div_clk_o), rt(DIV_T[p_cfg.divider_source_sel]));
      check("lf", 8'(lowfreq_clk_o), rt(LF_T[p_cfg.lowfreq_source_sel]));
      check("hf", 8'(highfreq_clk_o), rt(p_cfg.highfreq_source_sel == 4'h0 ? 0 : -1));
      check("1mhz", {7'h00, one_mhz_ref_o}, {7'h00, p_cfg.one_mhz_ref_enable & p_pins[0]});
      check("mode", {7'h00, spi_mode_o}, {7'h00, p_strap});
      if (p_strap == p_strap2) begin
        check("sclk", {7'h00, spi_sclk_o}, {7'h00, p_strap & p_addr});
        if (!p_strap) check("addr", {7'h00, i2c_addr_sel_o}, {7'h00, p_addr});
      end
      // Miso cfg counts only under I2C; in SPI the engine owns the pin
      oe_e[0] = p_mode ? p_mo : p_cfg.ctrl_miso_pin_cfg == 4'h3;
      oe_e[1] = p_cfg.port1_frameclk_pin_cfg == 4'h4;
      oe_e[2] = p_cfg.port1_serout_pin_cfg == 4'h3;
      oe_e[3] = p_cfg.port2_frameclk_pin_cfg == 4'h4;
      oe_e[4] = p_cfg.port2_bitclk_pin_cfg == 4'h4;
      oe_e[5] = p_cfg.gp1_pin_cfg == 5'h04;
      oe_e[6] = p_cfg.gp2_pin_cfg == 5'h04;
      omask = ~oe_e & {6'h3f, ~p_mode};
      check("pin oe", {1'b0, pin_oe_o}, {1'b0, oe_e});
      check("idle out", {1'b0, pin_out_o & omask}, 8'h00);
      // Driven clock-out terminals carry the divided clock of the previous edge
      cmask = oe_e & {6'h3f, ~p_mode};
      check("clk out", {1'b0, pin_out_o & cmask}, {1'b0, cmask & {7{m_dco_old}}});
      if (p_mode && p_mo) check("miso", {7'h00, pin_out_o[0]}, {7'h00, p_md});
    end
  end
  // ****************************************************************
  // Stimulus
  // ****************************************************************
  // Codes run past each listed set so unlisted ones are hit too
  function automatic ctm_cfg_t rand_cfg();
    ctm_cfg_t c;
    c = '0;
    c.pll_source_sel = 4'($urandom % 9);
    c.adc_clk_source_sel = 4'($urandom % 11);
    c.dac_clk_source_sel = 4'($urandom % 11);
    c.divider_source_sel = 5'($urandom % 11) | ($urandom % 8 == 0 ? 5'h10 : 5'h00);
    c.clock_output_divider = 8'($urandom % 5);
    c.one_mhz_ref_enable = 1'($urandom);
    c.lowfreq_source_sel = 4'($urandom % 10);
    c.highfreq_source_sel = 4'($urandom % 3);
    c.port1_serin_pin_cfg = 2'($urandom % 3);
    c.port2_serin_pin_cfg = 2'($urandom % 3);
    c.port2_bitclk_pin_cfg = 4'($urandom % 6);
    c.port2_frameclk_pin_cfg = 4'($urandom % 6);
    c.port1_frameclk_pin_cfg = 4'($urandom % 6);
    c.port1_serout_pin_cfg = 4'($urandom % 6);
    c.ctrl_miso_pin_cfg = 4'($urandom % 6);
    c.gp1_pin_cfg = 5'($urandom % 6);
    c.gp2_pin_cfg = 5'($urandom % 6);
    c.gp3_pin_cfg = 5'($urandom % 6);
    return c;
  endfunction
  initial begin
    seed = $urandom(23);
    repeat (2) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    // All-zero fields: master clock feeds every selector input at once
    repeat (6) @(posedge ref_clk_i);
    for (int i = 0; i < 1500; i++) begin
      @(posedge ref_clk_i);
      if (i % 3 == 0 || i > 1200) cfg <= rand_cfg();
      strap <= (i / 100) % 2 == 1;
      addr <= 1'($urandom);
      miso_d <= 1'($urandom);
      miso_oe <= 1'($urandom);
      if (i == 800) reset_i <= 1'b1;
      if (i == 802) reset_i <= 1'b0;
    end
    repeat (3) @(posedge ref_clk_i);
    wrap_up();
  end
  // Run needs about 1500 cycles; a hang is cut at 5000
  initial begin
    #50000;
    fail_count++;
    wrap_up();
  end
endmodule // ctm_terminal_mux_tb
